// file: src/pps_pid_sleep.sv
// loop controller with deviation/window flags and sleep, AHB-Lite slave
// assumes process inputs come from logic on hclk, one AHB master
//
// Overview of operation
// - output drives feedback toward frequency-command setpoint
// - mode 00 off, 01 on, 02 reversed output
// - proportional gain 0.00..25.00 scales error
// - integral set as time 0.0..3600 s
// - integral gain 1/Ti, zero disables integrator
// - derivative time 0.0..100 s
// - feedback scale factor 0.01..99.99
// - feedback source: current, voltage, network, pulse, calc
// - error is SP-PV or its negation
// - output limit 0.0..100.0 percent of full scale
// - within limit, output unrestricted
// - beyond limit, output pulled to limit band
// - feed-forward: off, voltage or current input
// - deviation alarm when error exceeds level while the loop acts
// - window output when feedback outside low..high
// - monitored values multiplied by scale factor
// - sleep threshold 0..400.0 Hz, delay 0..25.5 s
// - loop on: sleep when loop output below threshold
// - loop off: sleep when command below threshold
// - wake after reference above threshold full delay
// - loop only acts when source select chooses it
`timescale 1ns/1ps
module pps_pid_sleep #(
  parameter int SAMPLE_CYCLES = pps_pkg::SAMPLE_CYC,
  parameter int STEP_SAMPLES  = pps_pkg::STEP_SAMPLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [15:0] freq_cmd,
  input  wire logic [15:0] current_input_terminal,
  input  wire logic [15:0] voltage_input,
  input  wire logic [15:0] network_input,
  input  wire logic [15:0] pulse_input,
  input  wire logic [15:0] calc_input,
  output logic [15:0]      out_freq,
  output logic             out_run,
  output logic             deviation_alarm_out,
  output logic             feedback_window_out
);
  if (SAMPLE_CYCLES < 8 || STEP_SAMPLES < 1 || STEP_SAMPLES > 1000) begin
    $error("pps_pid_sleep: sample parameters out of range");
  end

  function automatic logic [15:0] clip(input logic [15:0] v,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic signed [31:0] sat(input logic signed [31:0] v,
                                             input logic signed [31:0] m);
    sat = (v > m) ? m : ((v < -m) ? -m : v);
  endfunction

  function automatic logic [15:0] scale_mon(input logic [15:0] v,
                                            input logic [15:0] s);
    logic [31:0] p;
    p = (32'(v) * 32'(s)) / 32'(pps_pkg::UNITY);
    scale_mon = (p > 32'h0000FFFF) ? 16'hFFFF : p[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait, read data registered in the address phase

  logic [15:0] ctrl, kp, ti, td, scale, limit;
  logic [15:0] dev_lvl, win_lo, win_hi, thr, dly;
  logic [15:0] mon_pv, mon_out;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        addr_ok;
  logic [31:0] next_rdata;
  pps_pkg::pps_sleep_t sleep_st;

  assign addr_ok = hsel && hready && htrans[1];

  always_comb begin
    next_rdata = 32'h00000000;
    if (haddr[7:0] == pps_pkg::OFS_CTRL) begin
      next_rdata[15:0] = ctrl;
    end else if (haddr[7:0] == pps_pkg::OFS_KP) begin
      next_rdata[15:0] = kp;
    end else if (haddr[7:0] == pps_pkg::OFS_TI) begin
      next_rdata[15:0] = ti;
    end else if (haddr[7:0] == pps_pkg::OFS_TD) begin
      next_rdata[15:0] = td;
    end else if (haddr[7:0] == pps_pkg::OFS_SCALE) begin
      next_rdata[15:0] = scale;
    end else if (haddr[7:0] == pps_pkg::OFS_LIMIT) begin
      next_rdata[15:0] = limit;
    end else if (haddr[7:0] == pps_pkg::OFS_DEVLVL) begin
      next_rdata[15:0] = dev_lvl;
    end else if (haddr[7:0] == pps_pkg::OFS_WINLO) begin
      next_rdata[15:0] = win_lo;
    end else if (haddr[7:0] == pps_pkg::OFS_WINHI) begin
      next_rdata[15:0] = win_hi;
    end else if (haddr[7:0] == pps_pkg::OFS_THR) begin
      next_rdata[15:0] = thr;
    end else if (haddr[7:0] == pps_pkg::OFS_DLY) begin
      next_rdata[15:0] = dly;
    end else if (haddr[7:0] == pps_pkg::OFS_STATUS) begin
      next_rdata = {13'h0000, feedback_window_out, deviation_alarm_out,
                    sleep_st == pps_pkg::PPS_ASLEEP, out_freq};
    end else if (haddr[7:0] == pps_pkg::OFS_MONPV) begin
      next_rdata[15:0] = mon_pv;
    end else if (haddr[7:0] == pps_pkg::OFS_MONOUT) begin
      next_rdata[15:0] = mon_out;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr   <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        hrdata <= (haddr[31:8] == 24'h000000) ? next_rdata : 32'h00000000;
      end
    end
  end

  // out-of-range settings are pulled into range so the math never overflows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl    <= pps_pkg::CTRL_RST;
      kp      <= pps_pkg::KP_RST;
      ti      <= pps_pkg::TI_RST;
      td      <= pps_pkg::TD_RST;
      scale   <= pps_pkg::SCALE_RST;
      limit   <= pps_pkg::ZERO_RST;
      dev_lvl <= pps_pkg::ZERO_RST;
      win_lo  <= pps_pkg::ZERO_RST;
      win_hi  <= pps_pkg::ZERO_RST;
      thr     <= pps_pkg::ZERO_RST;
      dly     <= pps_pkg::ZERO_RST;
    end else if (ce && wr_pend) begin
      if (wr_addr == pps_pkg::OFS_CTRL) begin
        ctrl <= hwdata[15:0] & pps_pkg::CTRL_MASK;
      end else if (wr_addr == pps_pkg::OFS_KP) begin
        kp <= clip(hwdata[15:0], 16'h0000, pps_pkg::KP_MAX);
      end else if (wr_addr == pps_pkg::OFS_TI) begin
        ti <= clip(hwdata[15:0], 16'h0000, pps_pkg::TI_MAX);
      end else if (wr_addr == pps_pkg::OFS_TD) begin
        td <= clip(hwdata[15:0], 16'h0000, pps_pkg::TD_MAX);
      end else if (wr_addr == pps_pkg::OFS_SCALE) begin
        scale <= clip(hwdata[15:0], pps_pkg::SCALE_MIN,
                      pps_pkg::SCALE_MAX);
      end else if (wr_addr == pps_pkg::OFS_LIMIT) begin
        limit <= clip(hwdata[15:0], 16'h0000, pps_pkg::LIMIT_MAX);
      end else if (wr_addr == pps_pkg::OFS_DEVLVL) begin
        dev_lvl <= hwdata[15:0];
      end else if (wr_addr == pps_pkg::OFS_WINLO) begin
        win_lo <= hwdata[15:0];
      end else if (wr_addr == pps_pkg::OFS_WINHI) begin
        win_hi <= hwdata[15:0];
      end else if (wr_addr == pps_pkg::OFS_THR) begin
        thr <= clip(hwdata[15:0], 16'h0000, pps_pkg::THR_MAX);
      end else if (wr_addr == pps_pkg::OFS_DLY) begin
        dly <= clip(hwdata[15:0], 16'h0000, pps_pkg::DLY_MAX);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample tick

  logic [31:0] tick_cnt;
  logic        tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b0;
    end else if (ce) begin
      tick     <= (tick_cnt == 32'(SAMPLE_CYCLES - 1));
      tick_cnt <= (tick_cnt == 32'(SAMPLE_CYCLES - 1)) ? 32'h00000000
                                                       : tick_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // loop arithmetic, evaluated on each tick

  pps_pkg::pps_mode_t mode;
  logic               loop_act;
  logic [15:0]        pv, ff;
  logic signed [31:0] err, err_prev, acc, next_acc;
  logic signed [31:0] p_term, i_term, d_term, u_raw, u_sat, sp;
  logic signed [31:0] lim_abs, fs;
  logic [15:0]        loop_out, target;

  assign mode     = pps_pkg::pps_mode_t'(ctrl[pps_pkg::CTRL_MODE +: 2]);
  assign loop_act = (mode != pps_pkg::PPS_LOOP_OFF)
                    && ctrl[pps_pkg::CTRL_FSRC];
  assign fs       = 32'(pps_pkg::FULL_SCALE);
  assign sp       = 32'(freq_cmd);

  always_comb begin
    case (pps_pkg::pps_pvsrc_t'(ctrl[pps_pkg::CTRL_PVSRC +: 3]))
      pps_pkg::PPS_PV_VOLT:  pv = voltage_input;
      pps_pkg::PPS_PV_NET:   pv = network_input;
      pps_pkg::PPS_PV_PULSE: pv = pulse_input;
      pps_pkg::PPS_PV_CALC:  pv = calc_input;
      default:               pv = current_input_terminal;
    endcase
    case (pps_pkg::pps_ff_t'(ctrl[pps_pkg::CTRL_FF +: 2]))
      pps_pkg::PPS_FF_VOLT: ff = voltage_input;
      pps_pkg::PPS_FF_CUR:  ff = current_input_terminal;
      default:              ff = 16'h0000;
    endcase
  end

  always_comb begin
    err      = ctrl[pps_pkg::CTRL_REV] ? 32'(pv) - sp : sp - 32'(pv);
    next_acc = sat(acc + err, 32'sh3FFFFFFF);
    // settings are cast signed, else a negative error turns huge
    p_term   = (err * $signed(32'(kp))) / 32'sd100;
    i_term   = (ti == 16'h0000) ? 32'sd0
             : sat(next_acc / $signed(32'(ti) * 32'(STEP_SAMPLES)),
                   fs);
    d_term   = sat((err - err_prev) * $signed(32'(td))
                   * 32'(STEP_SAMPLES), fs);
    u_raw    = p_term + i_term + d_term + $signed(32'(ff));
    if (mode == pps_pkg::PPS_LOOP_REV) begin
      u_raw = -u_raw;
    end
    u_sat    = (u_raw < 0) ? 32'sd0 : ((u_raw > fs) ? fs : u_raw);
    lim_abs  = (32'(limit) * fs) / 32'sd1000;
    if (u_sat > sp + lim_abs) begin
      u_sat = sp + lim_abs;
    end else if (u_sat < sp - lim_abs) begin
      u_sat = (sp < lim_abs) ? 32'sd0 : sp - lim_abs;
    end
  end

  // integrator state is dropped whenever the loop is idle or Ti is zero,
  // so re-enabling starts without a stale windup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc      <= 32'sd0;
      err_prev <= 32'sd0;
      loop_out <= 16'h0000;
    end else if (ce && tick) begin
      acc      <= (loop_act && ti != 16'h0000) ? next_acc : 32'sd0;
      err_prev <= err;
      loop_out <= loop_act ? u_sat[15:0] : 16'h0000;
    end
  end

  assign target = loop_act ? loop_out : freq_cmd;

  ////////////////////////////////////////////////////////////////////////
  // sleep: reference is loop output when the loop is on, else command

  logic [15:0] sleep_ref;
  logic [31:0] wake_cnt;
  logic [31:0] wake_need;

  assign sleep_ref = (mode != pps_pkg::PPS_LOOP_OFF) ? loop_out
                                                     : freq_cmd;
  assign wake_need = 32'(dly) * 32'(STEP_SAMPLES);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_st <= pps_pkg::PPS_AWAKE;
      wake_cnt <= 32'h00000000;
    end else if (ce && tick) begin
      case (sleep_st)
        pps_pkg::PPS_AWAKE: begin
          wake_cnt <= 32'h00000000;
          if (sleep_ref < thr) begin
            sleep_st <= pps_pkg::PPS_ASLEEP;
          end
        end
        default: begin
          if (sleep_ref <= thr) begin
            wake_cnt <= 32'h00000000;
          end else if (wake_cnt >= wake_need) begin
            sleep_st <= pps_pkg::PPS_AWAKE;
          end else begin
            wake_cnt <= wake_cnt + 32'h1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, flags and scaled monitors

  logic [31:0] err_abs;
  assign err_abs = (err < 0) ? 32'(-err) : 32'(err);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_freq            <= 16'h0000;
      out_run             <= 1'b0;
      deviation_alarm_out <= 1'b0;
      feedback_window_out <= 1'b0;
      mon_pv              <= 16'h0000;
      mon_out             <= 16'h0000;
    end else if (ce) begin
      out_run  <= (sleep_st == pps_pkg::PPS_AWAKE);
      out_freq <= (sleep_st == pps_pkg::PPS_AWAKE) ? target : 16'h0000;
      deviation_alarm_out <= loop_act && (err_abs > 32'(dev_lvl));
      feedback_window_out <= (pv < win_lo) || (pv > win_hi);
      mon_pv  <= scale_mon(pv, scale);
      mon_out <= scale_mon(target, scale);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_sleep_zero;
    @(posedge hclk) disable iff (!hresetn)
    ce && sleep_st == pps_pkg::PPS_ASLEEP |=> out_freq == 16'h0000 && !out_run;
  endproperty
  a_sleep_zero: assert property (p_sleep_zero)
    else $error("output not off while asleep");

  property p_fall_asleep;
    @(posedge hclk) disable iff (!hresetn)
    ce && tick && sleep_st == pps_pkg::PPS_AWAKE && sleep_ref < thr
    |=> sleep_st == pps_pkg::PPS_ASLEEP;
  endproperty
  a_fall_asleep: assert property (p_fall_asleep)
    else $error("did not sleep below threshold");

  property p_no_early_wake;
    @(posedge hclk) disable iff (!hresetn)
    ce && tick && sleep_st == pps_pkg::PPS_ASLEEP && wake_cnt < wake_need
    |=> sleep_st == pps_pkg::PPS_ASLEEP;
  endproperty
  a_no_early_wake: assert property (p_no_early_wake)
    else $error("woke before delay elapsed");

  property p_limit_band;
    @(posedge hclk) disable iff (!hresetn)
    ce && tick && loop_act
    |=> 32'(loop_out) <= $past(sp) + $past(lim_abs);
  endproperty
  a_limit_band: assert property (p_limit_band)
    else $error("loop output above limit band");

  property p_int_off;
    @(posedge hclk) disable iff (!hresetn)
    ce && tick && ti == 16'h0000 |=> acc == 32'sd0;
  endproperty
  a_int_off: assert property (p_int_off)
    else $error("integrator active with zero time");

  property p_loop_idle;
    @(posedge hclk) disable iff (!hresetn)
    ce && tick && !loop_act |=> loop_out == 16'h0000;
  endproperty
  a_loop_idle: assert property (p_loop_idle)
    else $error("loop output while loop not selected");

  property p_window;
    @(posedge hclk) disable iff (!hresetn)
    ce && (pv < win_lo) ##1 ce |-> feedback_window_out;
  endproperty
  a_window: assert property (p_window)
    else $error("window flag missing below low bound");

  property p_tick_period;
    @(posedge hclk) disable iff (!hresetn)
    tick && ce |=> !tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("sample tick longer than one cycle");
endmodule

// file: src/pps_pkg.sv
// constants, field layout and encodings of the loop controller block
// assumes a 40 MHz hclk and 16-bit process words in 0.1 Hz units
package pps_pkg;
  // timing
  localparam int CLK_NS       = 25;
  localparam int SAMPLE_NS    = 1000000;
  localparam int SAMPLE_CYC   = SAMPLE_NS / CLK_NS;
  localparam int STEP_NS      = 100000000;
  localparam int STEP_SAMPLES = STEP_NS / SAMPLE_NS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_KP     = 8'h04;
  localparam logic [7:0] OFS_TI     = 8'h08;
  localparam logic [7:0] OFS_TD     = 8'h0C;
  localparam logic [7:0] OFS_SCALE  = 8'h10;
  localparam logic [7:0] OFS_LIMIT  = 8'h14;
  localparam logic [7:0] OFS_DEVLVL = 8'h18;
  localparam logic [7:0] OFS_WINLO  = 8'h1C;
  localparam logic [7:0] OFS_WINHI  = 8'h20;
  localparam logic [7:0] OFS_THR    = 8'h24;
  localparam logic [7:0] OFS_DLY    = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_MONPV  = 8'h30;
  localparam logic [7:0] OFS_MONOUT = 8'h34;

  // control register fields
  localparam int CTRL_MODE  = 0;
  localparam int CTRL_REV   = 2;
  localparam int CTRL_FF    = 3;
  localparam int CTRL_PVSRC = 5;
  localparam int CTRL_FSRC  = 8;
  localparam logic [15:0] CTRL_MASK = 16'h01FF;

  // setting ranges (fixed point units)
  localparam logic [15:0] KP_MAX     = 16'h09C4;
  localparam logic [15:0] TI_MAX     = 16'h8CA0;
  localparam logic [15:0] TD_MAX     = 16'h03E8;
  localparam logic [15:0] SCALE_MIN  = 16'h0001;
  localparam logic [15:0] SCALE_MAX  = 16'h270F;
  localparam logic [15:0] LIMIT_MAX  = 16'h03E8;
  localparam logic [15:0] THR_MAX    = 16'h0FA0;
  localparam logic [15:0] DLY_MAX    = 16'h00FF;
  localparam logic [15:0] FULL_SCALE = 16'h0FA0;
  localparam logic [15:0] UNITY      = 16'h0064;

  // reset values
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [15:0] KP_RST    = 16'h0064;
  localparam logic [15:0] TI_RST    = 16'h000A;
  localparam logic [15:0] TD_RST    = 16'h0000;
  localparam logic [15:0] SCALE_RST = 16'h0064;
  localparam logic [15:0] ZERO_RST  = 16'h0000;

  typedef enum logic [1:0] {
    PPS_LOOP_OFF = 2'b00,
    PPS_LOOP_ON  = 2'b01,
    PPS_LOOP_REV = 2'b10
  } pps_mode_t;

  typedef enum logic [2:0] {
    PPS_PV_CUR   = 3'b000,
    PPS_PV_VOLT  = 3'b001,
    PPS_PV_NET   = 3'b010,
    PPS_PV_PULSE = 3'b011,
    PPS_PV_CALC  = 3'b100
  } pps_pvsrc_t;

  typedef enum logic [1:0] {
    PPS_FF_OFF  = 2'b00,
    PPS_FF_VOLT = 2'b01,
    PPS_FF_CUR  = 2'b10
  } pps_ff_t;

  typedef enum logic {
    PPS_AWAKE  = 1'b0,
    PPS_ASLEEP = 1'b1
  } pps_sleep_t;
endpackage

// file: bench/pps_sensor_model.sv
// process sensor model: five feedback words from one process value
// assumes hclk is shared with the loop block; words are registered
`timescale 1ns/1ps
module pps_sensor_model (
  input  wire logic        hclk,
  input  wire logic [15:0] pv_base,
  output logic      [15:0] cur_word,
  output logic      [15:0] volt_word,
  output logic      [15:0] net_word,
  output logic      [15:0] pulse_word,
  output logic      [15:0] calc_word
);
  // sources sit 100 apart, so a wrong source pick shows at once
  always_ff @(posedge hclk) begin
    cur_word   <= pv_base;
    volt_word  <= pv_base + 16'h0064;
    net_word   <= pv_base + 16'h00C8;
    pulse_word <= pv_base + 16'h012C;
    calc_word  <= pv_base + 16'h0190;
  end
endmodule

// file: bench/pps_pid_sleep_tb.sv
// self-checking bench for the loop controller with sleep
// assumes short sample counts (16 cycles, 2 samples per step)
`timescale 1ns/1ps
module pps_pid_sleep_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] freq_cmd, pv_base, out_freq;
  logic [15:0] cur_w, volt_w, net_w, pulse_w, calc_w;
  logic        out_run, dev_alarm, win_out;
  logic        ce;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;

  pps_pid_sleep #(.SAMPLE_CYCLES(16), .STEP_SAMPLES(2)) pps_pid_sleep_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .freq_cmd(freq_cmd),
    .current_input_terminal(cur_w), .voltage_input(volt_w),
    .network_input(net_w), .pulse_input(pulse_w), .calc_input(calc_w),
    .out_freq(out_freq), .out_run(out_run),
    .deviation_alarm_out(dev_alarm), .feedback_window_out(win_out));

  pps_sensor_model pps_sensor_model_inst (
    .hclk(hclk), .pv_base(pv_base), .cur_word(cur_w),
    .volt_word(volt_w), .net_word(net_w), .pulse_word(pulse_w),
    .calc_word(calc_w));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hangs end here; the tests need about 2000 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_mismatch++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp okay", 32'(hresp), 32'h00000000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, a, {16'h0000, d}, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h00000000, d);
  endtask

  // five sample ticks, enough for the loop output to settle
  task automatic settle();
    repeat (80) @(posedge hclk);
  endtask

  task automatic wait_run();
    for (int i = 0; i < 100 && out_run !== 1'b1; i++) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] v;
    logic [7:0]  ofs [0:6] = '{pps_pkg::OFS_KP, pps_pkg::OFS_TI,
      pps_pkg::OFS_TD, pps_pkg::OFS_SCALE, pps_pkg::OFS_LIMIT,
      pps_pkg::OFS_THR, pps_pkg::OFS_DLY};
    logic [15:0] wv [0:6] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000,
      16'hFFFF, 16'hFFFF, 16'hFFFF};
    logic [15:0] ev [0:6] = '{16'h09C4, 16'h8CA0, 16'h03E8, 16'h0001,
      16'h03E8, 16'h0FA0, 16'h00FF};
    rd(pps_pkg::OFS_CTRL, v);
    check("ctrl reset", v, 32'h00000000);
    rd(pps_pkg::OFS_KP, v);
    check("kp reset", v, 32'h00000064);
    rd(pps_pkg::OFS_TI, v);
    check("ti reset", v, 32'h0000000A);
    rd(pps_pkg::OFS_SCALE, v);
    check("scale reset", v, 32'h00000064);
    wr(8'h3C, 16'h1234);
    rd(8'h3C, v);
    check("unmapped", v, 32'h00000000);
    // settings beyond range are clipped to the range ends
    for (int i = 0; i < 7; i++) begin
      wr(ofs[i], wv[i]);
      rd(ofs[i], v);
      check("clip", v, {16'h0000, ev[i]});
    end
    wr(pps_pkg::OFS_KP, 16'h0064);
    wr(pps_pkg::OFS_TI, 16'h0000);
    wr(pps_pkg::OFS_TD, 16'h0000);
    wr(pps_pkg::OFS_SCALE, 16'h0064);
    wr(pps_pkg::OFS_THR, 16'h0000);
    wr(pps_pkg::OFS_DLY, 16'h0000);
  endtask

  task automatic t_source();
    logic [31:0] v;
    freq_cmd <= 16'h07D0;
    pv_base  <= 16'h0064;
    for (int s = 0; s < 5; s++) begin
      wr(pps_pkg::OFS_CTRL, 16'h0101 | 16'(s << 5));
      settle();
      check("loop out", out_freq, 32'(1900 - 100 * s));
      rd(pps_pkg::OFS_MONPV, v);
      check("mon pv", v, 32'(100 + 100 * s));
    end
    wr(pps_pkg::OFS_SCALE, 16'h00C8);
    rd(pps_pkg::OFS_MONPV, v);
    check("mon pv x2", v, 32'h000003E8);
    rd(pps_pkg::OFS_MONOUT, v);
    check("mon out x2", v, 32'h00000BB8);
    wr(pps_pkg::OFS_SCALE, 16'h0064);
    wr(pps_pkg::OFS_CTRL, 16'h0001);
    settle();
    check("source off", out_freq, 32'h000007D0);
    wr(pps_pkg::OFS_CTRL, 16'h0100);
    settle();
    check("loop off", out_freq, 32'h000007D0);
    wr(pps_pkg::OFS_CTRL, 16'h0109);
    settle();
    check("ff volt", out_freq, 32'h00000834);
    wr(pps_pkg::OFS_CTRL, 16'h0111);
    settle();
    check("ff cur", out_freq, 32'h000007D0);
  endtask

  task automatic t_limit();
    logic [15:0] ctl [0:4] = '{16'h0101, 16'h0101, 16'h0105, 16'h0102,
      16'h0106};
    logic [15:0] kp [0:4] = '{16'h0064, 16'h09C4, 16'h09C4, 16'h09C4,
      16'h09C4};
    logic [15:0] ev [0:4] = '{16'h03E8, 16'h0578, 16'h0258, 16'h0258,
      16'h0578};
    freq_cmd <= 16'h03E8;
    pv_base  <= 16'h0000;
    wr(pps_pkg::OFS_LIMIT, 16'h0064);
    // band is 1000 +/- 400: linear, high clip, inverted, reversed
    for (int i = 0; i < 5; i++) begin
      wr(pps_pkg::OFS_KP, kp[i]);
      wr(pps_pkg::OFS_CTRL, ctl[i]);
      settle();
      check("limit", out_freq, {16'h0000, ev[i]});
    end
    wr(pps_pkg::OFS_LIMIT, 16'h0000);
    settle();
    check("limit zero", out_freq, 32'h000003E8);
    wr(pps_pkg::OFS_LIMIT, 16'h03E8);
    wr(pps_pkg::OFS_CTRL, 16'h0101);
    wr(pps_pkg::OFS_KP, 16'h0000);
    settle();
    check("no integ", out_freq, 32'h00000000);
    wr(pps_pkg::OFS_TI, 16'h0001);
    settle();
    check("integ", 32'(out_freq != 16'h0000), 32'h00000001);
    wr(pps_pkg::OFS_TI, 16'h0000);
    wr(pps_pkg::OFS_KP, 16'h0064);
  endtask

  task automatic t_flags();
    freq_cmd <= 16'h07D0;
    pv_base  <= 16'h0064;
    wr(pps_pkg::OFS_CTRL, 16'h0101);
    wr(pps_pkg::OFS_DEVLVL, 16'h0032);
    repeat (4) @(posedge hclk);
    check("dev high", 32'(dev_alarm), 32'h00000001);
    wr(pps_pkg::OFS_DEVLVL, 16'h1000);
    repeat (4) @(posedge hclk);
    check("dev low", 32'(dev_alarm), 32'h00000000);
    wr(pps_pkg::OFS_WINLO, 16'h0096);
    wr(pps_pkg::OFS_WINHI, 16'h01C2);
    repeat (4) @(posedge hclk);
    check("win below", 32'(win_out), 32'h00000001);
    wr(pps_pkg::OFS_CTRL, 16'h0121);
    repeat (4) @(posedge hclk);
    check("win inside", 32'(win_out), 32'h00000000);
    wr(pps_pkg::OFS_CTRL, 16'h0181);
    repeat (4) @(posedge hclk);
    check("win above", 32'(win_out), 32'h00000001);
  endtask

  task automatic t_sleep();
    logic [31:0] v;
    freq_cmd <= 16'h012C;
    wr(pps_pkg::OFS_CTRL, 16'h0000);
    wr(pps_pkg::OFS_THR, 16'h01F4);
    wr(pps_pkg::OFS_DLY, 16'h0001);
    settle();
    check("cmd sleep", 32'(out_run), 32'h00000000);
    check("cmd sleep f", out_freq, 32'h00000000);
    rd(pps_pkg::OFS_STATUS, v);
    check("status", v, 32'h00050000);
    // enable low freezes the wake count, so no wake however long
    ce       <= 1'b0;
    freq_cmd <= 16'h03E8;
    repeat (60) @(posedge hclk);
    check("frozen", 32'(out_run), 32'h00000000);
    ce       <= 1'b1;
    // wake needs three qualifying ticks; 30 cycles hold two at most
    repeat (30) @(posedge hclk);
    check("early wake", 32'(out_run), 32'h00000000);
    wait_run();
    check("wake", 32'(out_run), 32'h00000001);
    check("wake f", out_freq, 32'h000003E8);
    pv_base <= 16'h03B6;
    wr(pps_pkg::OFS_CTRL, 16'h0101);
    settle();
    check("loop sleep", 32'(out_run), 32'h00000000);
    pv_base <= 16'h0000;
    wait_run();
    check("loop wake", 32'(out_run), 32'h00000001);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn  = 1'b0;
    ce       = 1'b1;
    hsel     = 1'b0;
    haddr    = 32'h00000000;
    htrans   = 2'b00;
    hwrite   = 1'b0;
    hsize    = 3'b010;
    hwdata   = 32'h00000000;
    freq_cmd = 16'h0000;
    pv_base  = 16'h0000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_source();
    t_limit();
    t_flags();
    t_sleep();
    conclude();
  end
endmodule
